// ---- rtl/counter_cmd_device.sv ----
/*
 Counter module end: start-up self-test timing, run and error indicators,
 control word check and decode, list termination, output enables, output
 rate limit and internal chaining of the first five counters.
 Assumes the counter logic sits on the user side on the same clock and acts
 on the dispatched opcode and selection.
*/
`timescale 1ns/10ps
`default_nettype none
`include "counter_cmd_regs.svh"

// Behaviour
// - self-test at start-up, error lamp on
// - tests pass, run lamp flashes
// - steady run after error-free parameterize commands
// - no interrupt while controller disables outputs
// - error lamp, run off on fault
// - counter output rate capped at 40 kHz
// - first five counters chain internally
// - opcode high byte, selection low byte
// - words come direct, indirect or listed
// - global codes 00..06, empty selection
// - opcodes 11..18 only counters one-five
// - opcodes 31..39 any counter one-seven
// - opcodes 71..77 counters and global registers
// - test and list opcodes need argument; series takes 0..7
// - block read/write never from lists
// - end-of-list stops the list
// - host ends lists shorter than five
// - module reset reruns self-test, error lamp
// - after reset unparameterized, outputs off
// - extended variant clears counter values
// - passed reset flashes; host must parameterize
// - outputs-off command disables all outputs
// - no counter selected gives error 03
// - counter six/seven on five-only gives 02
module counter_cmd_device
	import counter_cmd_pkg::*;
#(
	parameter int unsigned SELFTEST_CYCLES = `SELFTEST_CYCLES,
	parameter int unsigned FLASH_CYCLES    = `FLASH_CYCLES,
	parameter int unsigned MIN_GAP_CYCLES  = `MIN_GAP_CYCLES,
	parameter bit          EXTENDED        = 1'b1
) (
	input  wire logic       clk_in,
	input  wire logic       reset_n_in,
	cw_link.dev             link,
	input  wire logic       selftest_fail_in,
	input  wire logic       fault_in,
	input  wire logic       irq_event_in,
	input  wire logic [4:0] src_pulse_in,
	input  wire logic [4:0] chain_cfg_in,
	output logic            cmd_valid_out,
	output logic      [7:0] cmd_op_out,
	output logic      [7:0] cmd_sel_out,
	output logic      [6:0] outputs_en_out,
	output logic            params_valid_out,
	output logic            clear_values_out,
	output logic            err_led_out,
	output logic            run_led_out,
	output logic      [4:0] counter_pulse_out,
	output logic      [4:0] chain_in_out
);

	localparam int TW = $clog2(SELFTEST_CYCLES + 1);
	localparam int FW = $clog2(FLASH_CYCLES + 1);
	localparam int GW = $clog2(MIN_GAP_CYCLES + 1);

	typedef struct packed {
		dev_state_e        st;
		logic [TW-1:0]     tmr;
		logic [FW-1:0]     fcnt;
		logic              flash;
		logic              params_ok;
		logic              skip;
		logic [2:0]        idx;
		logic [6:0]        out_en;
		logic              ans_v;
		logic [7:0]        ans_err;
		logic              irq;
		logic              cmd_v;
		logic [7:0]        op;
		logic [7:0]        sel;
		logic              clr;
		logic [4:0][GW-1:0] gap;
		logic [4:0]        pulse;
		logic [4:0]        chain;
		logic              err_led;
		logic              run_led;
	} dev_s;

	dev_s q, d;

	// selection bit 0 is the global registers, bits 1..7 are counters 1..7
	function automatic logic [7:0] cw_error(input logic [15:0] w, input src_e s);
		logic [7:0] op;
		logic [7:0] sel;
		op  = w[15:8];
		sel = w[7:0];
		cw_error = `ERR_ILLEGAL;
		if (op <= `OP_GLOBAL_HI) begin
			cw_error = (sel == 8'h00) ? `ERR_NONE : `ERR_ILLEGAL;
		end else if (op >= `OP_C5_LO && op <= `OP_C5_HI) begin
			if (sel[7:1] == 7'h00) begin
				cw_error = `ERR_NO_SEL;
			end else if (sel[7:6] != 2'h0) begin
				cw_error = `ERR_RANGE;
			end else begin
				cw_error = sel[0] ? `ERR_ILLEGAL : `ERR_NONE;
			end
		end else if (op >= `OP_C7_LO && op <= `OP_C7_HI) begin
			if (sel[7:1] == 7'h00) begin
				cw_error = `ERR_NO_SEL;
			end else begin
				cw_error = sel[0] ? `ERR_ILLEGAL : `ERR_NONE;
			end
		end else if (op >= `OP_PG_LO && op <= `OP_PG_HI) begin
			cw_error = (sel == 8'h00) ? `ERR_NO_SEL : `ERR_NONE;
		end else if (op == `OP_TEST) begin
			cw_error = (sel == 8'h00) ? `ERR_ILLEGAL : `ERR_NONE;
		end else if (op == `OP_LIST) begin
			cw_error = (sel != 8'h00 && sel <= `LIST_NUM_HI) ? `ERR_NONE : `ERR_ILLEGAL;
		end else if (op == `OP_SER_RD || op == `OP_SER_CLR) begin
			cw_error = (sel <= `SERIES_NUM_HI) ? `ERR_NONE : `ERR_ILLEGAL;
		end else if (op == `OP_BLK_RD || op == `OP_BLK_WR) begin
			if (s == SRC_LIST) begin
				cw_error = `ERR_SOURCE;
			end else begin
				cw_error = (sel == 8'h00) ? `ERR_NO_SEL : `ERR_NONE;
			end
		end
	endfunction

	logic       take;
	logic [7:0] err;

	// words are not taken while the self-test runs
	assign link.cw_ready = (q.st != DEV_TEST);
	assign take          = link.cw_valid && link.cw_ready;
	assign err           = cw_error(link.cw_word, link.cw_src);

	always_comb begin
		d = q;
		d.ans_v = 1'b0;
		d.cmd_v = 1'b0;
		d.clr   = 1'b0;
		// events during the disable are dropped, not held for later
		d.irq = irq_event_in && !link.output_disable;

		case (q.st)
			DEV_TEST: begin
				d.tmr = q.tmr + 1'b1;
				if (q.tmr == TW'(SELFTEST_CYCLES - 1)) begin
					d.tmr = '0;
					d.st  = selftest_fail_in ? DEV_FAIL : DEV_RUN;
				end
			end
			DEV_FAIL: begin
				d.st = DEV_FAIL;
			end
			DEV_RUN: begin
				if (fault_in) begin
					d.st = DEV_FAIL;
				end
			end
			default: begin
				d.st = DEV_TEST;
			end
		endcase

		if (take) begin
			d.ans_v   = 1'b1;
			d.ans_err = `ERR_NONE;
			if (link.cw_src == SRC_LIST && link.cw_list_first) begin
				d.skip = 1'b0;
				d.idx  = 3'h0;
			end
			if (link.cw_src == SRC_LIST && (d.skip || d.idx == `LIST_LEN)) begin
				d.ans_err = `ERR_NONE;
			end else begin
				if (link.cw_src == SRC_LIST) begin
					d.idx = d.idx + 1'b1;
				end
				if (q.st == DEV_FAIL && link.cw_word[15:8] != `OP_RESET) begin
					d.ans_err = `ERR_ILLEGAL;
				end else begin
					d.ans_err = err;
				end
				if (d.ans_err == `ERR_NONE) begin
					case (link.cw_word[15:8])
						`OP_END: begin
							d.skip = (link.cw_src == SRC_LIST);
						end
						`OP_RESET: begin
							d.st        = DEV_TEST;
							d.tmr       = '0;
							d.params_ok = 1'b0;
							d.out_en    = 7'h00;
							d.clr       = EXTENDED;
							d.skip      = 1'b0;
						end
						`OP_OUT_OFF: begin
							d.out_en = 7'h00;
						end
						`OP_OUT_ON: begin
							d.out_en = 7'h7f;
						end
						`OP_PARAM, `OP_REWRITE, `OP_BASIC: begin
							d.params_ok = 1'b1;
						end
						default: begin
							d.params_ok = q.params_ok;
						end
					endcase
					if (link.cw_word[15:8] != `OP_END) begin
						d.cmd_v = 1'b1;
						d.op    = link.cw_word[15:8];
						d.sel   = link.cw_word[7:0];
					end
				end
			end
		end

		// slow blink; only while tested but not yet parameterized
		if (d.st == DEV_RUN && !d.params_ok) begin
			d.fcnt = q.fcnt + 1'b1;
			if (q.fcnt == FW'(FLASH_CYCLES - 1)) begin
				d.fcnt  = '0;
				d.flash = !q.flash;
			end
		end else begin
			d.fcnt  = '0;
			d.flash = 1'b1;
		end

		// pulses closer than the minimum gap are dropped rather than delayed,
		// so a too-fast source loses counts instead of drifting in time
		for (int i = 0; i < 5; i++) begin
			d.pulse[i] = 1'b0;
			if (q.gap[i] != '0) begin
				d.gap[i] = q.gap[i] - 1'b1;
			end
			if (src_pulse_in[i] && q.gap[i] == '0 && q.out_en[i]) begin
				d.pulse[i] = 1'b1;
				d.gap[i]   = GW'(MIN_GAP_CYCLES - 1);
			end
		end
		d.chain[0] = 1'b0;
		for (int i = 1; i < 5; i++) begin
			d.chain[i] = chain_cfg_in[i] && d.pulse[i-1];
		end

		d.err_led = (d.st != DEV_RUN) || fault_in;
		d.run_led = (d.st == DEV_RUN) && !fault_in && (d.params_ok || d.flash);
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			q         <= '0;
			q.st      <= DEV_TEST;
			q.flash   <= 1'b1;
			q.err_led <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign link.ans_valid    = q.ans_v;
	assign link.ans_err      = q.ans_err;
	assign link.irq          = q.irq;
	assign cmd_valid_out     = q.cmd_v;
	assign cmd_op_out        = q.op;
	assign cmd_sel_out       = q.sel;
	assign outputs_en_out    = q.out_en;
	assign params_valid_out  = q.params_ok;
	assign clear_values_out  = q.clr;
	assign err_led_out       = q.err_led;
	assign run_led_out       = q.run_led;
	assign counter_pulse_out = q.pulse;
	assign chain_in_out      = q.chain;

endmodule

`default_nettype wire

// ---- rtl/counter_cmd_host.sv ----
/*
 Controller end: takes control words from software through a small register
 port and hands them to the module over the link, one at a time.
 Assumes a master that keeps to one-cycle strobes and the same clock as the link.
*/
`timescale 1ns/10ps
`default_nettype none
`include "counter_cmd_regs.svh"

module counter_cmd_host
	import counter_cmd_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	cw_link.host             link,
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [31:0] rdata_out
);

	typedef struct packed {
		logic        odis;
		logic        pend;
		logic [15:0] word;
		src_e        src;
		logic        first;
		logic        done;
		logic [7:0]  err;
		logic [31:0] rdata;
	} host_s;

	host_s q, d;

	always_comb begin
		d = q;
		d.rdata = '0;
		if (link.cw_valid && link.cw_ready) begin
			d.pend = 1'b0;
		end
		if (wr_in && addr_in == `REG_CTRL) begin
			d.odis = wdata_in[`CTRL_ODIS_BIT];
		end
		// a new word while one is pending is dropped; software polls the pending bit
		if (wr_in && addr_in == `REG_CMD && !q.pend) begin
			d.pend  = 1'b1;
			d.word  = wdata_in[15:0];
			d.src   = src_e'(wdata_in[`CMD_SRC_LO +: 2]);
			d.first = wdata_in[`CMD_FIRST_BIT];
		end
		// an answer landing with the clear still counts
		if (wr_in && addr_in == `REG_STATUS && wdata_in[`STAT_DONE_BIT]) begin
			d.done = 1'b0;
		end
		if (link.ans_valid) begin
			d.done = 1'b1;
			d.err  = link.ans_err;
		end
		if (rd_in) begin
			case (addr_in)
				`REG_CTRL: begin
					d.rdata[`CTRL_ODIS_BIT] = q.odis;
				end
				`REG_CMD: begin
					d.rdata = {13'h0000, q.first, 2'(q.src), q.word};
				end
				`REG_STATUS: begin
					d.rdata[`STAT_PEND_BIT] = q.pend;
					d.rdata[`STAT_DONE_BIT] = q.done;
					d.rdata[`STAT_IRQ_BIT]  = link.irq;
					d.rdata[`STAT_ERR_LO +: 8] = q.err;
				end
				default: begin
					d.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			q <= '{odis: 1'b0, pend: 1'b0, word: 16'h0000, src: SRC_DIRECT, first: 1'b0,
			       done: 1'b0, err: 8'h00, rdata: 32'h00000000};
		end else begin
			q <= d;
		end
	end

	// word codes and selection fields pass through untouched; the module checks them
	assign link.cw_valid       = q.pend;
	assign link.cw_word        = q.word;
	assign link.cw_src         = q.src;
	assign link.cw_list_first  = q.first;
	assign link.output_disable = q.odis;
	assign rdata_out           = q.rdata;

endmodule

`default_nettype wire

// ---- rtl/counter_cmd_pkg.sv ----
/*
 Types shared by both ends of the control word link.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package counter_cmd_pkg;

	typedef enum logic [1:0] {
		SRC_DIRECT   = 2'h0,
		SRC_INDIRECT = 2'h1,
		SRC_LIST     = 2'h2
	} src_e;

	typedef enum logic [2:0] {
		DEV_TEST = 3'b001,
		DEV_FAIL = 3'b010,
		DEV_RUN  = 3'b100
	} dev_state_e;

endpackage

`default_nettype wire

// ---- rtl/counter_cmd_regs.svh ----
/*
 Offsets, field positions, command codes, error codes and timing
 counts of the counter module command path. Assumes the includer compiles
 under a 250 MHz clock.
*/
`ifndef COUNTER_CMD_REGS_SVH
`define COUNTER_CMD_REGS_SVH

`define CLK_FREQ_HZ        250000000
`define SELFTEST_TIME_MS   500
`define SELFTEST_CYCLES    (`SELFTEST_TIME_MS * (`CLK_FREQ_HZ / 1000))
`define FLASH_HALF_MS      250
`define FLASH_CYCLES       (`FLASH_HALF_MS * (`CLK_FREQ_HZ / 1000))
`define MAX_OUT_FREQ_KHZ   40
`define MIN_GAP_CYCLES     ((`CLK_FREQ_HZ / 1000 + `MAX_OUT_FREQ_KHZ - 1) / `MAX_OUT_FREQ_KHZ)
`define LIST_LEN           3'h5

`define OP_END             8'h00
`define OP_RESET           8'h01
`define OP_OUT_OFF         8'h02
`define OP_OUT_ON          8'h03
`define OP_GLOBAL_HI       8'h06
`define OP_C5_LO           8'h11
`define OP_C5_HI           8'h18
`define OP_C7_LO           8'h31
`define OP_C7_HI           8'h39
`define OP_PG_LO           8'h71
`define OP_PG_HI           8'h77
`define OP_PARAM           8'h71
`define OP_REWRITE         8'h73
`define OP_BASIC           8'h74
`define OP_TEST            8'h81
`define OP_LIST            8'h82
`define OP_SER_RD          8'h83
`define OP_SER_CLR         8'h84
`define OP_BLK_RD          8'hf1
`define OP_BLK_WR          8'hf2
`define LIST_NUM_HI        8'h07
`define SERIES_NUM_HI      8'h07

`define ERR_NONE           8'h00
`define ERR_ILLEGAL        8'h01
`define ERR_RANGE          8'h02
`define ERR_NO_SEL         8'h03
`define ERR_SOURCE         8'h04

`define REG_CTRL           8'h00
`define REG_CMD            8'h04
`define REG_STATUS         8'h08
`define CTRL_ODIS_BIT      0
`define CMD_SRC_LO         16
`define CMD_FIRST_BIT      18
`define STAT_PEND_BIT      0
`define STAT_DONE_BIT      1
`define STAT_IRQ_BIT       2
`define STAT_ERR_LO        8

`endif

// ---- rtl/cw_link.sv ----
/*
 Control word link between the controller end and the counter module end.
 Assumes both ends run on the same clock; the testbench instantiates it.
*/
`timescale 1ns/10ps
`default_nettype none

interface cw_link;
	import counter_cmd_pkg::*;

	logic       cw_valid;
	logic       cw_ready;
	logic [15:0] cw_word;
	src_e       cw_src;
	logic       cw_list_first;
	logic       ans_valid;
	logic [7:0] ans_err;
	logic       output_disable;
	logic       irq;

	modport dev (
		input  cw_valid, cw_word, cw_src, cw_list_first, output_disable,
		output cw_ready, ans_valid, ans_err, irq
	);

	modport host (
		output cw_valid, cw_word, cw_src, cw_list_first, output_disable,
		input  cw_ready, ans_valid, ans_err, irq
	);
endinterface

`default_nettype wire

// ---- test/counter_cmd_chk.sv ----
/*
 Checker on the control word link: answer timing, error codes, list end, interrupt gating.
 Assumes the bench instantiates it beside the link, on the link's clock and reset.
*/
`timescale 1ns/10ps
`default_nettype none

module counter_cmd_chk
	import counter_cmd_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        cw_valid,
	input  wire logic        cw_ready,
	input  wire logic [15:0] cw_word,
	input  wire src_e        cw_src,
	input  wire logic        cw_list_first,
	input  wire logic        ans_valid,
	input  wire logic [7:0]  ans_err,
	input  wire logic        output_disable,
	input  wire logic        irq
);
	logic       take;
	logic       direct;
	logic [7:0] op;
	logic [7:0] sel;
	logic [2:0] cnt_q;
	logic       done_q;

	assign take   = cw_valid && cw_ready;
	assign direct = cw_src != SRC_LIST;
	assign op     = cw_word[15:8];
	assign sel    = cw_word[7:0];

	// own count of executed list words, so a wrong cap inside the design shows up
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_q  <= 3'h0;
			done_q <= 1'b0;
		end else if (take && !direct && (cw_list_first || !done_q)) begin
			cnt_q  <= cw_list_first ? 3'h1 : cnt_q + 3'h1;
			done_q <= (op == 8'h00) || (!cw_list_first && cnt_q == 3'h4);
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_retest;
		!cw_ready [*8] ##[1:40] cw_ready;
	endsequence

	sequence s_reset_word;
		take && direct && cw_word == 16'h0100;
	endsequence

	startup_test_a: assert property ($rose(reset_n_in) |-> s_retest)
		else $error("words accepted during start-up test");
	reset_retest_a: assert property (s_reset_word |=> s_retest)
		else $error("module reset did not rerun the test");
	take_answer_a: assert property (take |=> ans_valid)
		else $error("no answer one cycle after take");
	answer_cause_a: assert property (ans_valid |-> $past(take))
		else $error("answer without a taken word");
	irq_gate_a: assert property (output_disable |=> !irq)
		else $error("interrupt while outputs disabled");
	no_select_a: assert property (take && direct && (op inside {[8'h11:8'h18], [8'h31:8'h39]})
		&& sel[7:1] == 7'h00 |=> ans_err == 8'h03) else $error("missing no-selection code");
	five_only_a: assert property (take && direct && (op inside {[8'h11:8'h18]})
		&& sel[7:6] != 2'h0 && !sel[0] |=> ans_err == 8'h02) else $error("missing range code");
	global_sel_a: assert property (take && direct && op <= 8'h06 && sel != 8'h00 |=> ans_err == 8'h01)
		else $error("global word with selection accepted");
	list_skip_a: assert property (take && !direct && !cw_list_first && done_q |=> ans_err == 8'h00)
		else $error("word after list end not ignored");
	list_block_a: assert property (take && !direct && cw_list_first && (op inside {8'hf1, 8'hf2})
		|=> ans_err == 8'h04) else $error("block word accepted from a list");
endmodule

`default_nettype wire

// ---- test/test_counter_module_command_decoder.sv ----
/*
 Self-checking bench: host end and module end joined by the link, driven over the host register port.
 Assumes package, link, both ends and the checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, s, e) begin n_checks++; if ((s) !== (e)) begin err_count++; $display("BAD %s exp %h seen %h", nm, e, s); end end

module test_counter_module_command_decoder;
	import counter_cmd_pkg::*;
	localparam int ST  = 20;
	localparam int FL  = 8;
	localparam int GAP = 4;
	localparam logic [23:0] EDGE_W [11] = '{24'h031100, 24'h021140, 24'h033100, 24'h037100, 24'h018100, 24'h018200,
		24'h018208, 24'h018408, 24'h008300, 24'h03f100, 24'h010201};
	int          err_count = 0;
	int          n_checks = 0;
	logic        clk_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic [7:0]  addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic        selftest_fail_in = 1'b0;
	logic        fault_in = 1'b0;
	logic        irq_event_in = 1'b0;
	logic [4:0]  src_pulse_in = 5'h00;
	logic [4:0]  chain_cfg_in = 5'h00;
	logic [31:0] rdata_out;
	logic        cmd_valid_out, params_valid_out, clear_values_out, err_led_out, run_led_out;
	logic [7:0]  cmd_op_out, cmd_sel_out;
	logic [6:0]  outputs_en_out;
	logic [4:0]  counter_pulse_out, chain_in_out;
	logic        cleared = 1'b0;
	logic [24:0] note;
	logic [24:0] exp_q [$];

	cw_link link ();
	counter_cmd_host i_counter_cmd_host (.clk_in, .reset_n_in, .link(link.host), .addr_in, .wdata_in, .wr_in,
		.rd_in, .rdata_out);
	counter_cmd_device #(.SELFTEST_CYCLES(ST), .FLASH_CYCLES(FL), .MIN_GAP_CYCLES(GAP), .EXTENDED(1'b1))
		i_counter_cmd_device (.clk_in, .reset_n_in, .link(link.dev), .selftest_fail_in, .fault_in, .irq_event_in,
		.src_pulse_in, .chain_cfg_in, .cmd_valid_out, .cmd_op_out, .cmd_sel_out, .outputs_en_out, .params_valid_out,
		.clear_values_out, .err_led_out, .run_led_out, .counter_pulse_out, .chain_in_out);
	counter_cmd_chk i_counter_cmd_chk (.clk_in, .reset_n_in, .cw_valid(link.cw_valid), .cw_ready(link.cw_ready),
		.cw_word(link.cw_word), .cw_src(link.cw_src), .cw_list_first(link.cw_list_first),
		.ans_valid(link.ans_valid), .ans_err(link.ans_err), .output_disable(link.output_disable), .irq(link.irq));

	always #2 clk_in = ~clk_in;

	// pre-edge values are read, so every sample is the settled value of the closing cycle
	always @(posedge clk_in) begin
		if (link.ans_valid === 1'b1 && exp_q.size() == 0) `CHK("spare_answer", 1'b1, 1'b0)
		if (link.ans_valid === 1'b1 && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			`CHK("ans_err", link.ans_err, note[23:16])
			`CHK("dispatch", cmd_valid_out, note[24])
			if (note[24]) `CHK("cmd", ({cmd_op_out, cmd_sel_out}), note[15:0])
		end
		if (clear_values_out === 1'b1) cleared = 1'b1;
	end

	function automatic logic [7:0] f_err(input logic [7:0] op, input logic [7:0] sel);
		if (op <= 8'h06) return (sel == 8'h00) ? 8'h00 : 8'h01;
		if (op >= 8'h11 && op <= 8'h18) return (sel[7:1] == 7'h0) ? 8'h03 : (sel[7:6] != 2'h0) ? 8'h02 : {7'h0, sel[0]};
		if (op >= 8'h31 && op <= 8'h39) return (sel[7:1] == 7'h0) ? 8'h03 : {7'h0, sel[0]};
		if ((op >= 8'h71 && op <= 8'h77) || op == 8'hf1 || op == 8'hf2) return (sel == 8'h00) ? 8'h03 : 8'h00;
		if (op == 8'h81) return (sel == 8'h00) ? 8'h01 : 8'h00;
		if (op == 8'h82) return (sel >= 8'h01 && sel <= 8'h07) ? 8'h00 : 8'h01;
		if (op == 8'h83 || op == 8'h84) return (sel <= 8'h07) ? 8'h00 : 8'h01;
		return 8'h01;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		@(posedge clk_in);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(posedge clk_in);
		`CHK("rdata", rdata_out & m, e)
	endtask

	task automatic send(input logic [15:0] w, input logic [1:0] s, input logic f, input logic [7:0] e, input logic dsp);
		int n;
		n = 0;
		exp_q.push_back({dsp, e, w});
		wr(8'h04, {13'h0, f, s, w});
		while (link.ans_valid !== 1'b1 && n < 200) begin
			@(posedge clk_in);
			n++;
		end
		if (n == 200) `CHK("answer", 1'b0, 1'b1)
		@(posedge clk_in);
	endtask

	task automatic wait_ready;
		int n;
		n = 0;
		while (link.cw_ready !== 1'b1 && n < 100) begin
			@(posedge clk_in);
			n++;
		end
		if (n == 100) `CHK("ready", 1'b0, 1'b1)
		repeat (2) @(posedge clk_in);
	endtask

	task automatic watch_run(output int tg);
		logic last;
		tg = 0;
		last = run_led_out;
		repeat (FL * 4) begin
			@(posedge clk_in);
			if (run_led_out !== last) tg++;
			last = run_led_out;
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#100000;
		err_count++;
		test_done();
	end

	initial begin
		int t;
		int k;
		logic [7:0] op;
		logic [7:0] sl;
		void'($urandom(16831));
		repeat (16) @(posedge clk_in);
		reset_n_in <= 1'b1;
		@(posedge clk_in);
		`CHK("leds", ({err_led_out, run_led_out}), 2'b10)
		send(16'h0300, SRC_DIRECT, 1'b0, 8'h00, 1'b1); // held in the host until the test ends
		`CHK("err_led", err_led_out, 1'b0)
		watch_run(t);
		`CHK("flash", (t >= 3 && params_valid_out === 1'b0), 1'b1)
		`CHK("out_en", outputs_en_out, 7'h7f)
		$display("test startup done");
		chain_cfg_in <= 5'h1e;
		src_pulse_in <= 5'h1f;
		k = 0;
		repeat (GAP * 6) begin
			@(posedge clk_in);
			if (counter_pulse_out[0] === 1'b1) k++;
			`CHK("chain", chain_in_out, ({counter_pulse_out[3:0] & chain_cfg_in[4:1], 1'b0}))
		end
		`CHK("rate", (k == 5 || k == 6), 1'b1)
		send(16'h0200, SRC_DIRECT, 1'b0, 8'h00, 1'b1);
		src_pulse_in <= 5'h00;
		@(posedge clk_in);
		`CHK("out_off", outputs_en_out, 7'h00)
		$display("test pulses done");
		for (int o = 2; o < 256; o++) begin
			op = o[7:0];
			sl = 8'($urandom());
			if (op >= 8'h11 && op <= 8'h18 && sl[7:6] != 2'h0) sl[0] = 1'b0;
			send({op, sl}, 2'($urandom_range(0, 1)), 1'b0, f_err(op, sl), f_err(op, sl) == 8'h00);
		end
		for (int i = 0; i < 11; i++) begin
			send(EDGE_W[i][15:0], SRC_DIRECT, 1'b0, EDGE_W[i][23:16], EDGE_W[i][23:16] == 8'h00);
		end
		$display("test decode done");
		send(16'h0100, SRC_DIRECT, 1'b0, 8'h00, 1'b1);
		`CHK("reset", ({err_led_out, params_valid_out, outputs_en_out}), 9'h100)
		`CHK("clear", cleared, 1'b1)
		wait_ready();
		watch_run(t);
		`CHK("flash", (t >= 3 && err_led_out === 1'b0), 1'b1)
		send(16'h7302, SRC_INDIRECT, 1'b0, 8'h00, 1'b1);
		watch_run(t);
		`CHK("steady", ({t == 0, run_led_out}), 2'b11)
		$display("test module reset done");
		send(16'h3102, SRC_LIST, 1'b1, 8'h00, 1'b1);
		send(16'h0000, SRC_LIST, 1'b0, 8'h00, 1'b0);
		send(16'h3100, SRC_LIST, 1'b0, 8'h00, 1'b0); // would answer 03 if it were run
		for (int i = 0; i < 6; i++) send(16'h3102, SRC_LIST, i == 0, 8'h00, i < 5);
		send(16'hf102, SRC_LIST, 1'b1, 8'h04, 1'b0);
		rd(8'h08, 32'h0000ff02, 32'h00000402);
		$display("test lists done");
		irq_event_in <= 1'b1;
		wr(8'h00, 32'h00000001);
		repeat (2) @(posedge clk_in);
		`CHK("irq_off", link.irq, 1'b0)
		rd(8'h00, 32'h00000001, 32'h00000001);
		rd(8'h40, 32'hffffffff, 32'h00000000);
		wr(8'h00, 32'h00000000);
		repeat (2) @(posedge clk_in);
		`CHK("irq_on", link.irq, 1'b1)
		irq_event_in <= 1'b0;
		$display("test interrupt done");
		fault_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		`CHK("fault", ({err_led_out, run_led_out}), 2'b10)
		fault_in         <= 1'b0;
		selftest_fail_in <= 1'b1;
		send(16'h0100, SRC_DIRECT, 1'b0, 8'h00, 1'b1);
		wait_ready();
		`CHK("test_bad", ({err_led_out, run_led_out}), 2'b10)
		selftest_fail_in <= 1'b0;
		send(16'h0100, SRC_DIRECT, 1'b0, 8'h00, 1'b1);
		wait_ready();
		`CHK("recover", err_led_out, 1'b0)
		`CHK("queue", exp_q.size(), 0)
		$display("test fault done");
		test_done();
	end
endmodule

`default_nettype wire
